// [dv/sar_cmp_model.sv]
// comparator and range flag model standing at the analog side
`default_nettype none
module sar_cmp_model (
   input  wire logic [17:0] pos_array, // trial word from the arrays
   input  wire logic [17:0] target,    // held level, offset binary
   input  wire logic        ovr,       // force overrange
   input  wire logic        unr,       // force underrange
   output logic             cmp_in,    // keep trial bit
   output logic             over_in,   // overrange flag
   output logic             under_in   // underrange flag
);
   timeunit 1ns;
   timeprecision 1ps;
   // combinational; settles within the cycle after the arrays move
   assign cmp_in   = (target >= pos_array);
   assign over_in  = ovr;
   assign under_in = unr;
endmodule
`default_nettype wire

// [dv/sar_seq_props.sv]
// port assertions for the sar conversion sequencer
`default_nettype none
module sar_seq_props #(
   parameter N       = 18,     // resolution
   parameter ACQ_CYC = 8,      // acquisition cycles
   parameter BIT_CYC = 1       // cycles per bit
) (
   input wire logic         core_clk,               // clock
   input wire logic         nrst,                   // reset, low
   input wire logic         convert_start,          // start pin
   input wire logic         cmp_in,                 // comparator
   input wire logic         over_in,                // overrange
   input wire logic         under_in,               // underrange
   input wire logic         positive_ground_switch, // high = closed
   input wire logic         negative_ground_switch, // high = closed
   input wire logic         arrays_to_input,        // tracking
   input wire logic [N-1:0] pos_array,              // trial word
   input wire logic [N-1:0] neg_array,              // mirror word
   input wire logic         busy,                   // converting
   input wire logic         done,                   // end pulse
   input wire logic         power_down,             // low power
   input wire logic [N-1:0] result                  // held code
);
   timeunit 1ns;
   timeprecision 1ps;
   // longest conversion allowed: sync, open, hold, bits, finish
   localparam int CONV_MAX = 8 + 18 * BIT_CYC;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ****************************************************************
   // conversion steps
   // ****************************************************************
   sequence s_open;
      !positive_ground_switch && !negative_ground_switch && arrays_to_input;
   endsequence
   sequence s_hold;
      !arrays_to_input;
   endsequence
   sequence s_conv;
      busy [*8];
   endsequence
   AST_OPEN_ORDER: assert property ($rose(busy) |-> s_open ##1 s_hold)
      else $error("ground switches did not open before arrays moved");
   AST_MSB_FIRST: assert property ($fell(arrays_to_input) |=>
      pos_array == {1'b1, {(N-1){1'b0}}})
      else $error("first trial is not the top bit");
   AST_MIRROR: assert property (pos_array != 0 |->
      neg_array == ~pos_array) else $error("arrays not mirrored");
   AST_IDLE: assert property (!busy |-> arrays_to_input &&
      positive_ground_switch && pos_array == 0)
      else $error("idle state not tracking the inputs");
   AST_BUSY_AWAKE: assert property (busy |-> !power_down)
      else $error("powered down while converting");
   AST_DONE_IDLE: assert property (done |->
      !busy && power_down ##1 !done)
      else $error("done pulse malformed");
   AST_HOLD: assert property ($changed(result) |-> done)
      else $error("result changed without done");
   AST_CONV_SPAN: assert property ($rose(busy) |->
      s_conv ##[1:CONV_MAX] done) else $error("conversion length wrong");
endmodule
bind sar_seq sar_seq_props #(.N(N), .ACQ_CYC(ACQ_CYC), .BIT_CYC(BIT_CYC))
   i_props (.core_clk(core_clk), .nrst(nrst),
   .convert_start(convert_start), .cmp_in(cmp_in), .over_in(over_in),
   .under_in(under_in), .positive_ground_switch(positive_ground_switch),
   .negative_ground_switch(negative_ground_switch),
   .arrays_to_input(arrays_to_input), .pos_array(pos_array),
   .neg_array(neg_array), .busy(busy), .done(done),
   .power_down(power_down), .result(result));
`default_nettype wire

// [dv/test_sar_conversion_sequencer.sv]
// self-checking bench for the sar conversion sequencer
`default_nettype none
module test_sar_conversion_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [17:0] CORNER [6] = '{18'h00000, 18'h3FFFF,
      18'h20000, 18'h20001, 18'h1FFFF, 18'h00001};
   logic        core_clk, nrst, convert_start, ovr, unr; // drives
   logic [17:0] target;                                  // held level
   wire logic   cmp_in, over_in, under_in;               // model out
   wire logic   psw, nsw, ati, busy, done, power_down;   // dut flags
   wire logic [17:0] pos_array, neg_array, result;       // dut words
   integer      failures, cmp_count, seed, i;            // bookkeeping
   sar_seq i_dut (.core_clk(core_clk), .nrst(nrst),
      .convert_start(convert_start), .cmp_in(cmp_in), .over_in(over_in),
      .under_in(under_in), .positive_ground_switch(psw),
      .negative_ground_switch(nsw), .arrays_to_input(ati),
      .pos_array(pos_array), .neg_array(neg_array), .busy(busy),
      .done(done), .power_down(power_down), .result(result));
   sar_cmp_model i_cmp (.pos_array(pos_array), .target(target),
      .ovr(ovr), .unr(unr), .cmp_in(cmp_in), .over_in(over_in),
      .under_in(under_in));
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic results;
      if (failures == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [17:0] seen,
                        input logic [17:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // expected code: flags win, over before under, else msb flipped
   function automatic logic [17:0] exp_code(input logic [17:0] raw,
                                            input logic o, input logic u);
      if (o) return 18'h1FFFF;
      if (u) return 18'h20000;
      return raw ^ 18'h20000;
   endfunction
   // one whole conversion, optionally poked while busy
   task automatic conv(input logic [17:0] raw, input logic o,
                       input logic u, input logic poke);
      logic [17:0] want;
      integer      k;
      time         t0;
      want = exp_code(raw, o, u);
      k = 0;
      @(posedge core_clk);
      target <= raw;
      ovr    <= o;
      unr    <= u;
      tick(2);
      convert_start <= 1'b1;
      t0 = $time;
      tick(4);
      convert_start <= 1'b0;
      if (poke) begin
         tick(6);
         convert_start <= 1'b1; // restart while busy is ignored
         tick(2);
         convert_start <= 1'b0;
      end
      while (done !== 1'b1) begin
         @(posedge core_clk);
         #1;
         k = k + 1;
         if (k > 200) begin
            failures = failures + 1;
            results();
         end
      end
      check("result", result, want);
      check("busy", busy, 1'b0);
      check("power_down", power_down, 1'b1);
      // conversion plus minimum acquisition must fit 40 cycles
      check("rate", 18'(($time - t0) / 25 + 8 <= 40), 18'h1);
      @(posedge core_clk);
      convert_start <= 1'b1; // too early in acquisition
      tick(6);
      #1;
      check("early_start", busy, 1'b0);
      check("held", result, want);
      @(posedge core_clk);
      convert_start <= 1'b0;
      tick(12);
   endtask
   // ****************************************************************
   // clock and main sequence
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      nrst = 1'b0;
      convert_start = 1'b0;
      ovr = 1'b0;
      unr = 1'b0;
      target = 18'h00000;
      failures = 0;
      cmp_count = 0;
      seed = 32'h1CB3;
      tick(12);
      #1;
      check("reset_flags", {psw, nsw, ati, busy, done, power_down},
            6'b111001);
      nrst <= 1'b1;
      tick(12);
      check("reset_code", result, 18'h00000);
      for (i = 0; i < 6; i++) conv(CORNER[i], 1'b0, 1'b0, 1'b0);
      conv(18'h15555, 1'b1, 1'b0, 1'b0);
      conv(18'h15555, 1'b0, 1'b1, 1'b1);
      conv(18'h0AAAA, 1'b1, 1'b1, 1'b0);
      for (i = 0; i < 24; i++) conv(18'($random(seed)), 1'b0, 1'b0, i[0]);
      results();
   end
endmodule
`default_nettype wire

// [rtl/sar_code_fmt.v]
// result formatter: offset binary search word to two's complement
`default_nettype none
`include "sar_regs.vh"
module sar_code_fmt #(
   parameter N = `SAR_BITS          // code width
) (
   input  wire [N-1:0] raw,         // offset binary search result
   input  wire         over,        // input above reference range
   input  wire         under,       // input below ground
   output reg  [N-1:0] code         // formatted code
);
   // ****************************************************************
   // format
   // ****************************************************************
   // msb inversion maps offset binary to two's complement
   always @* begin
      if (over)
         code = {1'b0, {(N-1){1'b1}}};
      else if (under)
         code = {1'b1, {(N-1){1'b0}}};
      else
         code = {~raw[N-1], raw[N-2:0]};
   end
endmodule
`default_nettype wire

// [rtl/sar_conv_clk.v]
// internal conversion clock: strobe generator for bit steps
`default_nettype none
module sar_conv_clk #(
   parameter DIV = 1                // cycles between strobes
) (
   input  wire core_clk,            // system clock
   input  wire nrst,                // async reset, active low
   input  wire run,                 // count while high
   output reg  step                 // one-cycle strobe
);
   // ****************************************************************
   // divider
   // ****************************************************************
   reg [7:0] cnt_r;                 // divider count

   // free-running while run; no external serial clock needed
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 8'h00;
         step  <= 1'b0;
      end else if (!run) begin
         cnt_r <= 8'h00;
         step  <= 1'b0;
      end else if (cnt_r == DIV[7:0] - 8'h01) begin
         cnt_r <= 8'h00;
         step  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         step  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [rtl/sar_regs.vh]
// constants shared by the sar conversion sequencer files
`ifndef SAR_REGS_VH
`define SAR_REGS_VH
// ****************************************************************
// resolution and code points
// ****************************************************************
`define SAR_BITS          18
`define SAR_CODE_MID      18'h00000
`define SAR_CODE_POS_FS   18'h1FFFF
`define SAR_CODE_NEG_FS   18'h20000
// ****************************************************************
// timing
// ****************************************************************
`define SAR_CLK_MHZ       40
`define SAR_RATE_SPS      1000000
// cycles per sample at the top rate: 40e6 / 1e6
`define SAR_CYC_PER_SAMPLE (`SAR_CLK_MHZ * 1000000 / `SAR_RATE_SPS)
// cycles of acquisition before a start is honoured
`define SAR_ACQ_CYC       8
// settle cycles per bit decision
`define SAR_BIT_CYC       1
`endif

// [rtl/sar_seq.v]
// sar conversion sequencer top: acquisition, bit search, result
// ****************************************************************
// How it works
// - convert_start rise after acquisition starts conversion
// - open ground switches, then arrays to ground
// - drive two 18-bit binary arrays, trial word and its complement
// - decide bits msb first from comparator
// - finish: back to acquire, code, busy
// - bit steps timed by internal conversion clock
// - full cycle fits one microsecond
// - low power between conversions automatically
// - code belongs to the same conversion
// - result is 18-bit two's complement
// - overrange gives positive full scale
// - underrange gives negative full scale
// ****************************************************************
`default_nettype none
`include "sar_regs.vh"
module sar_seq #(
   parameter N       = `SAR_BITS,    // resolution
   parameter ACQ_CYC = `SAR_ACQ_CYC, // minimum acquisition cycles
   parameter BIT_CYC = `SAR_BIT_CYC  // cycles per bit decision
) (
   input  wire         core_clk,               // 40 MHz clock
   input  wire         nrst,                   // async reset, low
   input  wire         convert_start,          // pin, async
   input  wire         cmp_in,                 // comparator latch
   input  wire         over_in,                // overrange flag, async
   input  wire         under_in,               // underrange flag, async
   output reg          positive_ground_switch, // high = closed
   output reg          negative_ground_switch, // high = closed
   output reg          arrays_to_input,        // high = track inputs
   output reg  [N-1:0] pos_array,              // 1 = element to ref
   output reg  [N-1:0] neg_array,              // 1 = element to ref
   output reg          busy,                   // conversion running
   output reg          done,                   // one-cycle pulse
   output reg          power_down,             // low power state
   output reg  [N-1:0] result                  // last code
);
   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] ST_ACQ  = 3'h0;  // tracking inputs
   localparam [2:0] ST_OPEN = 3'h1;  // ground switches open
   localparam [2:0] ST_HOLD = 3'h2;  // arrays moved to ground
   localparam [2:0] ST_BIT  = 3'h3;  // bit search
   localparam [2:0] ST_FIN  = 3'h4;  // output code

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   reg [2:0] s1_r;                   // first stage, read by s2 only
   reg [2:0] s2_r;                   // second stage
   reg       cnv_d_r;                // delayed start for edge detect

   // two stages on the start and range flag pins before any logic looks at them
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r    <= 3'h0;
         s2_r    <= 3'h0;
         cnv_d_r <= 1'b0;
      end else begin
         s1_r    <= {under_in, over_in, convert_start};
         s2_r    <= s1_r;
         cnv_d_r <= s2_r[0];
      end
   end

   wire cnv_s   = s2_r[0];           // synced start
   // comparator latch sits in the analog core on core_clk, so it is
   // same-domain; two sync stages would cost two cycles per bit and
   // push the whole cycle past one microsecond
   wire cmp_s   = cmp_in;            // comparator decision
   wire over_s  = s2_r[1];           // synced overrange
   wire under_s = s2_r[2];           // synced underrange
   wire cnv_rise = cnv_s & ~cnv_d_r; // start edge

   // ****************************************************************
   // sequencer registers
   // ****************************************************************
   reg [2:0]   st_r;                 // state
   reg [2:0]   st_nxt;
   reg [7:0]   acq_r;                // acquisition cycle count
   reg [7:0]   acq_nxt;
   reg [4:0]   bit_r;                // current bit index
   reg [4:0]   bit_nxt;
   reg [N-1:0] trial_r;              // search word
   reg [N-1:0] trial_nxt;
   reg         ovr_r;                // latched overrange
   reg         ovr_nxt;
   reg         und_r;                // latched underrange
   reg         und_nxt;
   reg [N-1:0] res_nxt;
   wire        step;                 // conversion clock strobe
   wire [N-1:0] fmt_code;            // formatted result

   // conversion clock runs only during the bit search
   sar_conv_clk #(
      .DIV  (BIT_CYC)
   ) u_clk (
      .core_clk (core_clk),
      .nrst     (nrst),
      .run      (st_nxt == ST_BIT),
      .step     (step)
   );

   // format from the search word of this very conversion
   sar_code_fmt #(
      .N (N)
   ) u_fmt (
      .raw   (trial_r),
      .over  (ovr_r),
      .under (und_r),
      .code  (fmt_code)
   );

   // one-hot mask of the bit under trial
   function [N-1:0] bit_mask;
      input [4:0] idx;
      begin
         bit_mask = {{(N-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   // ****************************************************************
   // next state
   // ****************************************************************
   // acquisition must finish before a start edge is honoured;
   // a start during conversion is ignored, the host must wait
   always @* begin
      st_nxt    = st_r;
      acq_nxt   = acq_r;
      bit_nxt   = bit_r;
      trial_nxt = trial_r;
      ovr_nxt   = ovr_r;
      und_nxt   = und_r;
      res_nxt   = result;
      case (st_r)
         ST_ACQ: begin
            if (acq_r != ACQ_CYC[7:0])
               acq_nxt = acq_r + 8'h01;
            if (cnv_rise && acq_r == ACQ_CYC[7:0]) begin
               st_nxt = ST_OPEN;
               ovr_nxt = over_s;
               und_nxt = under_s;
            end
         end
         ST_OPEN: begin
            st_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            st_nxt    = ST_BIT;
            bit_nxt   = N[4:0] - 5'h01;
            trial_nxt = bit_mask(N[4:0] - 5'h01);
         end
         ST_BIT: begin
            if (step) begin
               // comparator low: trial too big, drop the bit
               if (!cmp_s)
                  trial_nxt = trial_r & ~bit_mask(bit_r);
               if (bit_r == 5'h00)
                  st_nxt = ST_FIN;
               else begin
                  bit_nxt   = bit_r - 5'h01;
                  trial_nxt = (cmp_s ? trial_r
                               : trial_r & ~bit_mask(bit_r))
                              | bit_mask(bit_r - 5'h01);
               end
            end
         end
         ST_FIN: begin
            st_nxt  = ST_ACQ;
            acq_nxt = 8'h00;
            res_nxt = fmt_code;
         end
         default: begin
            st_nxt = ST_ACQ;
         end
      endcase
   end

   // ****************************************************************
   // state and output flops
   // ****************************************************************
   // every output comes from a flop; switches follow the state
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r    <= ST_ACQ;
         acq_r   <= 8'h00;
         bit_r   <= 5'h00;
         trial_r <= {N{1'b0}};
         ovr_r   <= 1'b0;
         und_r   <= 1'b0;
         result  <= `SAR_CODE_MID;
         positive_ground_switch <= 1'b1;
         negative_ground_switch <= 1'b1;
         arrays_to_input        <= 1'b1;
         pos_array  <= {N{1'b0}};
         neg_array  <= {N{1'b0}};
         busy       <= 1'b0;
         done       <= 1'b0;
         power_down <= 1'b1;
      end else begin
         st_r    <= st_nxt;
         acq_r   <= acq_nxt;
         bit_r   <= bit_nxt;
         trial_r <= trial_nxt;
         ovr_r   <= ovr_nxt;
         und_r   <= und_nxt;
         result  <= res_nxt;
         // ground switches open first, arrays leave inputs next
         positive_ground_switch <= (st_nxt == ST_ACQ);
         negative_ground_switch <= (st_nxt == ST_ACQ);
         arrays_to_input <= (st_nxt == ST_ACQ) ||
                            (st_nxt == ST_OPEN);
         // positive array carries the trial, negative array its complement
         pos_array <= (st_nxt == ST_BIT) ? trial_nxt
                      : {N{1'b0}};
         neg_array <= (st_nxt == ST_BIT) ? ~trial_nxt
                      : {N{1'b0}};
         busy <= (st_nxt != ST_ACQ);
         done <= (st_r == ST_FIN);
         // analog core idles in acquisition, no command needed
         power_down <= (st_nxt == ST_ACQ);
      end
   end

   // whole cycle: 8 acq + 2 + 18 bits + 1 + sync, well under 40
   // cycles of one microsecond at 40 MHz
endmodule
`default_nettype wire
